// File: hdl/cpoe_mem.sv
/*
 * Sample memory of the output FIFO: one write port, one read port whose
 * data come out of a register one cycle after the address.
 * Assumes the caller keeps the pointers and never reads a word written
 * in the same cycle.
 */
`timescale 1ns/100ps
module cpoe_mem (
	input wire logic clk_sys_i,
	input wire logic ce_i,
	input wire logic we_i,
	input wire logic [cpoe_pkg::FIFO_AW-1:0] waddr_i,
	input wire logic [cpoe_pkg::DATA_W-1:0] wdata_i,
	input wire logic [cpoe_pkg::FIFO_AW-1:0] raddr_i,
	output logic [cpoe_pkg::DATA_W-1:0] rdata_o
);

	logic [cpoe_pkg::DATA_W-1:0] mem [cpoe_pkg::FIFO_DEPTH];

	always_ff @(posedge clk_sys_i) begin
		if (ce_i) begin
			if (we_i) begin
				mem[waddr_i] <= wdata_i;
			end
			rdata_o <= mem[raddr_i];
		end
	end

endmodule : cpoe_mem

// File: hdl/cpoe_pkg.sv
/*
 * Shared constants of the counter pulse-output engine: register map,
 * field positions, reset values, FIFO sizing, state and mode encodings.
 * Assumes a single clock domain and the plain strobe register port.
 */
package cpoe_pkg;

	localparam int TICK_W = 16;
	localparam int FIFO_AW = 6;
	localparam int FIFO_DEPTH = 64;
	localparam int LVL_W = 7;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	////////////////////////////////////////////////////////////////////
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DFLT = 8'h04;
	localparam logic [7:0] OFS_DELAY = 8'h08;
	localparam logic [7:0] OFS_COUNT = 8'h0C;
	localparam logic [7:0] OFS_FIFO = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_SQW = 8'h18;
	localparam logic [7:0] OFS_SWP = 8'h1C;

	localparam int CTRL_ARM = 0;
	localparam int CTRL_SWP = 1;
	localparam int CTRL_CONT = 2;
	localparam int CTRL_REGEN_LO = 3;
	localparam int CTRL_SRC_FALL = 5;
	localparam int CTRL_SQW_EN = 6;
	localparam int CTRL_TERM_OE = 7;
	localparam int CTRL_FLUSH = 8;
	localparam int CTRL_W = 8;

	localparam int ST_UNDERFLOW = 0;
	localparam int ST_REFUSED = 1;
	localparam int ST_RUNNING = 2;
	localparam int ST_LOADED = 3;
	localparam int ST_PULSE = 4;
	localparam int ST_LEVEL_LO = 8;

	localparam int SQW_DIV_LO = 0;
	localparam int SQW_TB_LO = 5;
	localparam int SWP_INC_LO = 16;

	localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
	localparam logic [TICK_W-1:0] TICK_RESET = 16'h0002;
	localparam logic [4:0] DIV_RESET = 5'h01;

	localparam logic [1:0] REGEN_STD = 2'h0;
	localparam logic [1:0] REGEN_FIFO = 2'h1;
	localparam logic [1:0] REGEN_NONE = 2'h2;

	localparam logic [1:0] TB_20M = 2'h0;
	localparam logic [1:0] TB_10M = 2'h1;
	localparam logic [1:0] TB_100K = 2'h2;

	localparam logic [4:0] DIV_MIN = 5'h01;
	localparam logic [4:0] DIV_CEIL = 5'h10;

	typedef enum logic [2:0] {
		CPOE_OFF, CPOE_WAIT_GATE, CPOE_DELAY, CPOE_IDLE_PH, CPOE_ACTIVE_PH
	} cpoe_state_type;

	// Keeps a divisor inside its permitted range.
	function automatic logic [4:0] clamp_div(input logic [4:0] d);
		if (d < DIV_MIN) begin
			return DIV_MIN;
		end
		if (d > DIV_CEIL) begin
			return DIV_CEIL;
		end
		return d;
	endfunction : clamp_div

	// True when the edge now counted completes a phase of the given length.
	function automatic logic ticks_done(input logic [TICK_W-1:0] cnt,
			input logic [TICK_W-1:0] len);
		logic [TICK_W:0] need;
		need = (len == '0) ? {{TICK_W{1'b0}}, 1'b1} : {1'b0, len};
		return ({1'b0, cnt} + 1'b1) >= need;
	endfunction : ticks_done

endpackage : cpoe_pkg

// File: hdl/cpoe_sqw.sv
/*
 * Square-wave generator: divides a selected timebase by 1 to 16.
 * Assumes the timebase inputs are slow enough to be sampled as levels.
 */
`timescale 1ns/100ps
module cpoe_sqw (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic en_i,
	input wire logic [1:0] tb_sel_i,
	input wire logic [4:0] div_i,
	input wire logic tb_20m_i,
	input wire logic tb_100k_i,
	output logic sqw_o
);

	logic tb20_prev_q, tb20_prev_d;
	logic tb100_prev_q, tb100_prev_d;
	logic half_q, half_d;
	logic [4:0] cnt_q, cnt_d;
	logic out_q, out_d;
	logic rise20, rise100, tick, level;
	logic [4:0] div, low_len;

	always_comb begin
		rise20 = tb_20m_i & ~tb20_prev_q;
		rise100 = tb_100k_i & ~tb100_prev_q;
		tb20_prev_d = tb_20m_i;
		tb100_prev_d = tb_100k_i;
		half_d = rise20 ? ~half_q : half_q;
		// Three timebases; the unused code falls back to the slowest one.
		case (tb_sel_i)
			cpoe_pkg::TB_20M: begin
				tick = rise20;
				level = tb_20m_i;
			end
			cpoe_pkg::TB_10M: begin
				tick = rise20 & half_q;
				level = half_q;
			end
			default: begin
				tick = rise100;
				level = tb_100k_i;
			end
		endcase
		div = cpoe_pkg::clamp_div(div_i);
		// Rounding up gives D/2 for even D and the longer low half for odd D.
		low_len = 5'((6'(div) + 6'h01) >> 1);
		cnt_d = cnt_q;
		out_d = out_q;
		if (!en_i) begin
			cnt_d = '0;
			out_d = 1'b0;
		end else if (div == cpoe_pkg::DIV_MIN) begin
			out_d = level;
		end else if (tick) begin
			cnt_d = (cnt_q >= div - 5'h01) ? 5'h00 : cnt_q + 5'h01;
			out_d = (cnt_d >= low_len);
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			tb20_prev_q <= 1'b0;
			tb100_prev_q <= 1'b0;
			half_q <= 1'b0;
			cnt_q <= '0;
			out_q <= 1'b0;
		end else if (ce_i) begin
			tb20_prev_q <= tb20_prev_d;
			tb100_prev_q <= tb100_prev_d;
			half_q <= half_d;
			cnt_q <= cnt_d;
			out_q <= out_d;
		end
	end

	assign sqw_o = out_q;

endmodule : cpoe_sqw

// File: hdl/cpoe_top.sv
/*
 * Counter pulse-output engine: sample-clocked buffered pulse trains fed
 * from a FIFO, equivalent-time-sampling pulses, and a square-wave
 * generator routed to one routable I/O terminal.
 * Assumes Source, gate, sample clock and timebases are synchronous to
 * clk_sys_i and change no faster than every other clock.
 */
// Decided for this implementation: the address-and-strobe port and the address map.
// Behaviour
// - Sample clock swaps in next FIFO spec after pulse.
// - Finite run keeps last spec until stopped.
// - Default delay and spec until first sample clock.
// - Standard mode accepts sample writes whenever FIFO not full.
// - FIFO regeneration replays loaded set, refuses writes.
// - Empty FIFO at sample clock flags underflow.
// - Continuous mode consumes samples until stopped.
// - Square wave divides timebase by 1 to 16.
// - Timebase is 20 MHz, 10 MHz or 100 kHz.
// - Divisor one or even gives 50% duty.
// - Odd divisor: low (D+1)/2, high (D-1)/2.
// - Square wave shares no counter resources.
// - Terminal high-impedance after reset.
// - Output period is idle plus active ticks.
// - Ticks count selectable Source edges.
// - Delay after gate grows by increment each pulse.
// - Increment programmable from 0 to 255.
// - Growing delay continues until disarmed.
// - Gate edges ignored while pulse in progress.
`timescale 1ns/100ps
module cpoe_top (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [cpoe_pkg::ADDR_W-1:0] addr_i,
	input wire logic [cpoe_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [cpoe_pkg::DATA_W-1:0] rdata_o,
	input wire logic source_i,
	input wire logic gate_i,
	input wire logic sample_clk_i,
	input wire logic tb_20m_i,
	input wire logic tb_100k_i,
	output logic pulse_o,
	output logic sqw_o,
	output logic io_term_o,
	output logic io_term_oe_o
);

	localparam int TW = cpoe_pkg::TICK_W;
	localparam int AW = cpoe_pkg::FIFO_AW;

	cpoe_pkg::cpoe_state_type state_q, state_d;
	logic [cpoe_pkg::CTRL_W-1:0] ctrl_q, ctrl_d;
	logic [TW-1:0] dflt_idle_q, dflt_idle_d, dflt_act_q, dflt_act_d;
	logic [TW-1:0] init_dly_q, init_dly_d, count_q, count_d;
	logic [4:0] sqw_div_q, sqw_div_d;
	logic [1:0] sqw_tb_q, sqw_tb_d;
	logic [TW-1:0] swp_base_q, swp_base_d, swp_cur_q, swp_cur_d;
	logic [7:0] swp_inc_q, swp_inc_d;
	logic [TW-1:0] cur_idle_q, cur_idle_d, cur_act_q, cur_act_d;
	logic [TW-1:0] cnt_q, cnt_d, remain_q, remain_d;
	logic [AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
	logic [cpoe_pkg::LVL_W-1:0] level_q, level_d, level_dly_q, level_dly_d;
	logic pending_q, pending_d, loaded_q, loaded_d;
	logic underflow_q, underflow_d, refused_q, refused_d;
	logic src_prev_q, src_prev_d, samp_prev_q, samp_prev_d, gate_prev_q, gate_prev_d;
	logic pulse_q, pulse_d, term_q, term_d, term_oe_q, term_oe_d;
	logic [cpoe_pkg::DATA_W-1:0] rdata_q, rdata_d;
	logic [cpoe_pkg::DATA_W-1:0] mem_rdata;
	logic sqw_wave;
	logic src_edge, samp_edge, gate_edge, swp_mode, cont_mode, regen_fifo;
	logic avail, may_take, push, pop, flush;
	logic [1:0] regen;

	////////////////////////////////////////////////////////////////////
	// Sample FIFO storage; pointers and fill level live in this module.

	cpoe_mem u_mem (
		.clk_sys_i(clk_sys_i),
		.ce_i(ce_i),
		.we_i(push),
		.waddr_i(wr_ptr_q),
		.wdata_i(wdata_i),
		.raddr_i(rd_ptr_q),
		.rdata_o(mem_rdata)
	);

	// A separate divider so the pulse counters stay free for their own task.
	cpoe_sqw u_sqw (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.en_i(ctrl_q[cpoe_pkg::CTRL_SQW_EN]),
		.tb_sel_i(sqw_tb_q),
		.div_i(sqw_div_q),
		.tb_20m_i(tb_20m_i),
		.tb_100k_i(tb_100k_i),
		.sqw_o(sqw_wave)
	);

	////////////////////////////////////////////////////////////////////
	// Next-state logic for registers, FIFO and pulse sequencer.

	always_comb begin
		swp_mode = ctrl_q[cpoe_pkg::CTRL_SWP];
		cont_mode = ctrl_q[cpoe_pkg::CTRL_CONT];
		regen = ctrl_q[cpoe_pkg::CTRL_REGEN_LO +: 2];
		regen_fifo = (regen == cpoe_pkg::REGEN_FIFO);
		src_edge = ctrl_q[cpoe_pkg::CTRL_SRC_FALL] ? (src_prev_q & ~source_i)
			: (~src_prev_q & source_i);
		samp_edge = sample_clk_i & ~samp_prev_q;
		gate_edge = gate_i & ~gate_prev_q;
		// A word written last cycle is not yet on the registered read port.
		avail = (level_q != '0) && (level_dly_q != '0);
		may_take = cont_mode || (remain_q != '0);
		flush = wr_i && (addr_i == cpoe_pkg::OFS_CTRL) && wdata_i[cpoe_pkg::CTRL_FLUSH];

		state_d = state_q;
		ctrl_d = ctrl_q;
		dflt_idle_d = dflt_idle_q;
		dflt_act_d = dflt_act_q;
		init_dly_d = init_dly_q;
		count_d = count_q;
		sqw_div_d = sqw_div_q;
		sqw_tb_d = sqw_tb_q;
		swp_base_d = swp_base_q;
		swp_inc_d = swp_inc_q;
		swp_cur_d = swp_cur_q;
		cur_idle_d = cur_idle_q;
		cur_act_d = cur_act_q;
		cnt_d = cnt_q;
		remain_d = remain_q;
		wr_ptr_d = wr_ptr_q;
		rd_ptr_d = rd_ptr_q;
		level_d = level_q;
		level_dly_d = level_q;
		loaded_d = loaded_q;
		underflow_d = underflow_q;
		refused_d = refused_q;
		src_prev_d = source_i;
		samp_prev_d = sample_clk_i;
		gate_prev_d = gate_i;
		rdata_d = '0;
		push = 1'b0;
		pop = 1'b0;
		// A sample clock in the boundary cycle stays pending for the next pulse.
		pending_d = pending_q | (samp_edge & (state_q != cpoe_pkg::CPOE_OFF) & ~swp_mode);

		if (wr_i) begin
			case (addr_i)
				cpoe_pkg::OFS_CTRL: ctrl_d = wdata_i[cpoe_pkg::CTRL_W-1:0];
				cpoe_pkg::OFS_DFLT: begin
					dflt_idle_d = wdata_i[TW-1:0];
					dflt_act_d = wdata_i[2*TW-1:TW];
				end
				cpoe_pkg::OFS_DELAY: init_dly_d = wdata_i[TW-1:0];
				cpoe_pkg::OFS_COUNT: count_d = wdata_i[TW-1:0];
				cpoe_pkg::OFS_FIFO: begin
					// Writes go on while generating, except once a replay set is fixed or the FIFO is full.
					if (loaded_q || level_q == cpoe_pkg::LVL_W'(cpoe_pkg::FIFO_DEPTH)) begin
						refused_d = 1'b1;
					end else begin
						push = 1'b1;
					end
				end
				cpoe_pkg::OFS_STATUS: begin
					if (wdata_i[cpoe_pkg::ST_UNDERFLOW]) begin
						underflow_d = 1'b0;
					end
					if (wdata_i[cpoe_pkg::ST_REFUSED]) begin
						refused_d = 1'b0;
					end
				end
				cpoe_pkg::OFS_SQW: begin
					sqw_div_d = wdata_i[cpoe_pkg::SQW_DIV_LO +: 5];
					sqw_tb_d = wdata_i[cpoe_pkg::SQW_TB_LO +: 2];
				end
				cpoe_pkg::OFS_SWP: begin
					swp_base_d = wdata_i[TW-1:0];
					swp_inc_d = wdata_i[cpoe_pkg::SWP_INC_LO +: 8];
				end
				default: ;
			endcase
		end

		if (rd_i) begin
			case (addr_i)
				cpoe_pkg::OFS_CTRL: rdata_d[cpoe_pkg::CTRL_W-1:0] = ctrl_q;
				cpoe_pkg::OFS_DFLT: rdata_d = {dflt_act_q, dflt_idle_q};
				cpoe_pkg::OFS_DELAY: rdata_d[TW-1:0] = init_dly_q;
				cpoe_pkg::OFS_COUNT: rdata_d[TW-1:0] = count_q;
				cpoe_pkg::OFS_STATUS: begin
					rdata_d[cpoe_pkg::ST_UNDERFLOW] = underflow_q;
					rdata_d[cpoe_pkg::ST_REFUSED] = refused_q;
					rdata_d[cpoe_pkg::ST_RUNNING] = (state_q != cpoe_pkg::CPOE_OFF);
					rdata_d[cpoe_pkg::ST_LOADED] = loaded_q;
					rdata_d[cpoe_pkg::ST_PULSE] = pulse_q;
					rdata_d[cpoe_pkg::ST_LEVEL_LO +: cpoe_pkg::LVL_W] = level_q;
				end
				cpoe_pkg::OFS_SQW: begin
					rdata_d[cpoe_pkg::SQW_DIV_LO +: 5] = sqw_div_q;
					rdata_d[cpoe_pkg::SQW_TB_LO +: 2] = sqw_tb_q;
				end
				cpoe_pkg::OFS_SWP: rdata_d = {8'h00, swp_inc_q, swp_base_q};
				default: rdata_d = '0;
			endcase
		end

		if (src_edge) begin
			cnt_d = cnt_q + 1'b1;
		end

		case (state_q)
			cpoe_pkg::CPOE_OFF: begin
				cnt_d = '0;
				pending_d = 1'b0;
				if (ctrl_q[cpoe_pkg::CTRL_ARM]) begin
					// Defaults run until the first sample clock.
					cur_idle_d = dflt_idle_q;
					cur_act_d = dflt_act_q;
					remain_d = count_q;
					swp_cur_d = swp_base_q;
					loaded_d = regen_fifo & ~swp_mode;
					state_d = swp_mode ? cpoe_pkg::CPOE_WAIT_GATE : cpoe_pkg::CPOE_DELAY;
				end
			end
			cpoe_pkg::CPOE_WAIT_GATE: begin
				cnt_d = '0;
				// Only this state looks at the gate, so edges during a pulse are lost.
				if (gate_edge) begin
					state_d = cpoe_pkg::CPOE_DELAY;
				end
			end
			cpoe_pkg::CPOE_DELAY: begin
				if (src_edge && cpoe_pkg::ticks_done(cnt_q, swp_mode ? swp_cur_q : init_dly_q)) begin
					cnt_d = '0;
					state_d = swp_mode ? cpoe_pkg::CPOE_ACTIVE_PH : cpoe_pkg::CPOE_IDLE_PH;
				end
			end
			cpoe_pkg::CPOE_IDLE_PH: begin
				if (src_edge && cpoe_pkg::ticks_done(cnt_q, cur_idle_q)) begin
					cnt_d = '0;
					state_d = cpoe_pkg::CPOE_ACTIVE_PH;
				end
			end
			cpoe_pkg::CPOE_ACTIVE_PH: begin
				if (src_edge && cpoe_pkg::ticks_done(cnt_q, cur_act_q)) begin
					cnt_d = '0;
					if (swp_mode) begin
						// Wraps silently if the delay outgrows the tick width.
						swp_cur_d = swp_cur_q + TW'(swp_inc_q);
						state_d = cpoe_pkg::CPOE_WAIT_GATE;
					end else begin
						state_d = cpoe_pkg::CPOE_IDLE_PH;
						if (pending_q && may_take) begin
							pending_d = samp_edge;
							if (avail) begin
								// New spec only at the pulse boundary.
								cur_idle_d = mem_rdata[TW-1:0];
								cur_act_d = mem_rdata[2*TW-1:TW];
								pop = 1'b1;
								if (!cont_mode) begin
									remain_d = remain_q - 1'b1;
								end
							end else begin
								underflow_d = 1'b1;
							end
						end else if (pending_q) begin
							pending_d = samp_edge;
						end
					end
				end
			end
			default: state_d = cpoe_pkg::CPOE_OFF;
		endcase

		if (!ctrl_q[cpoe_pkg::CTRL_ARM]) begin
			state_d = cpoe_pkg::CPOE_OFF;
			loaded_d = 1'b0;
		end

		if (pop) begin
			if (loaded_q) begin
				// Replay wraps over the loaded set and never frees a word.
				rd_ptr_d = (level_q == cpoe_pkg::LVL_W'(rd_ptr_q) + 1'b1) ? '0
					: rd_ptr_q + 1'b1;
			end else begin
				rd_ptr_d = rd_ptr_q + 1'b1;
			end
		end
		if (push) begin
			wr_ptr_d = wr_ptr_q + 1'b1;
		end
		level_d = level_q + cpoe_pkg::LVL_W'(push)
			- cpoe_pkg::LVL_W'(pop & ~loaded_q);
		if (flush) begin
			wr_ptr_d = '0;
			rd_ptr_d = '0;
			level_d = '0;
		end

		pulse_d = (state_q == cpoe_pkg::CPOE_ACTIVE_PH);
		term_d = sqw_wave;
		term_oe_d = ctrl_q[cpoe_pkg::CTRL_TERM_OE];
	end

	////////////////////////////////////////////////////////////////////
	// State registers; everything holds while the clock enable is low.

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= cpoe_pkg::CPOE_OFF;
			ctrl_q <= cpoe_pkg::CTRL_RESET;
			dflt_idle_q <= cpoe_pkg::TICK_RESET;
			dflt_act_q <= cpoe_pkg::TICK_RESET;
			init_dly_q <= cpoe_pkg::TICK_RESET;
			count_q <= '0;
			sqw_div_q <= cpoe_pkg::DIV_RESET;
			sqw_tb_q <= cpoe_pkg::TB_20M;
			swp_base_q <= cpoe_pkg::TICK_RESET;
			swp_inc_q <= '0;
			swp_cur_q <= '0;
			cur_idle_q <= '0;
			cur_act_q <= '0;
			cnt_q <= '0;
			remain_q <= '0;
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			level_q <= '0;
			level_dly_q <= '0;
			pending_q <= 1'b0;
			loaded_q <= 1'b0;
			underflow_q <= 1'b0;
			refused_q <= 1'b0;
			src_prev_q <= 1'b0;
			samp_prev_q <= 1'b0;
			gate_prev_q <= 1'b0;
			pulse_q <= 1'b0;
			term_q <= 1'b0;
			term_oe_q <= 1'b0;
			rdata_q <= '0;
		end else if (ce_i) begin
			state_q <= state_d;
			ctrl_q <= ctrl_d;
			dflt_idle_q <= dflt_idle_d;
			dflt_act_q <= dflt_act_d;
			init_dly_q <= init_dly_d;
			count_q <= count_d;
			sqw_div_q <= sqw_div_d;
			sqw_tb_q <= sqw_tb_d;
			swp_base_q <= swp_base_d;
			swp_inc_q <= swp_inc_d;
			swp_cur_q <= swp_cur_d;
			cur_idle_q <= cur_idle_d;
			cur_act_q <= cur_act_d;
			cnt_q <= cnt_d;
			remain_q <= remain_d;
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
			level_q <= level_d;
			level_dly_q <= level_dly_d;
			pending_q <= pending_d;
			loaded_q <= loaded_d;
			underflow_q <= underflow_d;
			refused_q <= refused_d;
			src_prev_q <= src_prev_d;
			samp_prev_q <= samp_prev_d;
			gate_prev_q <= gate_prev_d;
			pulse_q <= pulse_d;
			term_q <= term_d;
			term_oe_q <= term_oe_d;
			rdata_q <= rdata_d;
		end
	end

	assign rdata_o = rdata_q;
	assign pulse_o = pulse_q;
	assign sqw_o = sqw_wave;
	assign io_term_o = term_q;
	assign io_term_oe_o = term_oe_q;

endmodule : cpoe_top

// File: verif/cpoe_src_model.sv
/*
 * Far-side signal model: Source ticks and the two timebases, each a free
 * running square wave with a settable half period.
 * Assumes clk_sys_i runs and rst_i is active high.
 */
`timescale 1ns/100ps
module cpoe_src_model #(
	parameter int SRC_HALF = 8,
	parameter int FAST_HALF = 3,
	parameter int SLOW_HALF = 20
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	output logic source_o,
	output logic tb_fast_o,
	output logic tb_slow_o
);
	localparam int HALF [3] = '{SRC_HALF, FAST_HALF, SLOW_HALF};
	int cnt_q [3];
	logic [2:0] lvl_q;

	////////////////////////////////////////
	// Every level lasts several clocks, so no Source edge can slip past.
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			lvl_q <= 3'h0;
			for (int i = 0; i < 3; i++) cnt_q[i] <= 0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				cnt_q[i] <= (cnt_q[i] == HALF[i] - 1) ? 0 : cnt_q[i] + 1;
				if (cnt_q[i] == HALF[i] - 1) lvl_q[i] <= ~lvl_q[i];
			end
		end
	end

	assign source_o = lvl_q[0];
	assign tb_fast_o = lvl_q[1];
	assign tb_slow_o = lvl_q[2];
endmodule : cpoe_src_model

// File: verif/cpoe_top_sva.sv
/*
 * Checker of the engine's ports: terminal state after reset, the cause of
 * every output change, read data timing.
 * Assumes one clock domain; bound into cpoe_top below.
 */
`timescale 1ns/100ps
module cpoe_top_sva (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [cpoe_pkg::DATA_W-1:0] rdata_o,
	input wire logic source_i,
	input wire logic tb_20m_i,
	input wire logic tb_100k_i,
	input wire logic pulse_o,
	input wire logic sqw_o,
	input wire logic io_term_o,
	input wire logic io_term_oe_o
);
	// Ages saturate so a long quiet spell never wraps into a false cause.
	logic [3:0] src_age_q, tb_age_q, wr_age_q;

	function automatic logic [3:0] age(input logic [3:0] a);
		return (a == 4'hF) ? a : a + 4'h1;
	endfunction : age

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			src_age_q <= 4'hF;
			tb_age_q <= 4'hF;
			wr_age_q <= 4'hF;
		end else begin
			src_age_q <= $changed(source_i) ? 4'h0 : age(src_age_q);
			tb_age_q <= ($changed(tb_20m_i) || $changed(tb_100k_i)) ? 4'h0 : age(tb_age_q);
			wr_age_q <= wr_i ? 4'h0 : age(wr_age_q);
		end
	end

	////////////////////////////////////////
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);

	sequence s_lone_change;
		$changed(pulse_o) && wr_age_q > 4'h5;
	endsequence
	property p_rst_quiet;
		$fell(rst_i) |-> !io_term_oe_o && !io_term_o;
	endproperty
	property p_rst_low;
		$fell(rst_i) |-> !pulse_o && !sqw_o;
	endproperty
	property p_term_data;
		$past(ce_i) |-> io_term_o == $past(sqw_o);
	endproperty
	property p_oe_cause;
		$changed(io_term_oe_o) |-> wr_age_q < 4'h4;
	endproperty
	property p_sqw_cause;
		$changed(sqw_o) |-> tb_age_q < 4'h6 || wr_age_q < 4'h6;
	endproperty
	property p_pulse_cause;
		$changed(pulse_o) |-> src_age_q < 4'h7 || wr_age_q < 4'h6;
	endproperty
	property p_pulse_stable;
		s_lone_change |=> $stable(pulse_o);
	endproperty
	property p_rd_idle;
		$past(ce_i) && !$past(rd_i) |-> rdata_o == '0;
	endproperty

	a_rst_quiet: assert property (p_rst_quiet) else $error("terminal active after reset");
	a_rst_low: assert property (p_rst_low) else $error("output high after reset");
	a_term_data: assert property (p_term_data) else $error("terminal data off");
	a_oe_cause: assert property (p_oe_cause) else $error("enable moved alone");
	a_sqw_cause: assert property (p_sqw_cause) else $error("square wave off timebase");
	a_pulse_cause: assert property (p_pulse_cause) else $error("pulse off Source");
	a_pulse_stable: assert property (p_pulse_stable) else $error("pulse glitch");
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
endmodule : cpoe_top_sva

bind cpoe_top cpoe_top_sva cpoe_top_sva_inst (.clk_sys_i, .rst_i, .ce_i, .wr_i, .rd_i, .rdata_o,
	.source_i, .tb_20m_i, .tb_100k_i, .pulse_o, .sqw_o, .io_term_o, .io_term_oe_o);

// File: verif/tb_top.sv
/*
 * Testbench of cpoe_top: register port tasks, square wave, sample-clocked
 * trains, regeneration modes and delays that grow per trigger.
 * Assumes the Source and timebase model and the bound checker.
 */
`timescale 1ns/100ps
module tb_top;
	localparam int SP = 16;
	localparam int P20 = 6;
	localparam int P100 = 40;
	localparam logic [7:0] R_CTL = cpoe_pkg::OFS_CTRL;
	localparam logic [7:0] R_FIFO = cpoe_pkg::OFS_FIFO;
	localparam logic [7:0] R_ST = cpoe_pkg::OFS_STATUS;
	localparam logic [31:0] ARM = 32'h1 << cpoe_pkg::CTRL_ARM;
	localparam logic [31:0] CONT = 32'h1 << cpoe_pkg::CTRL_CONT;
	localparam logic [31:0] SQ = (32'h1 << cpoe_pkg::CTRL_SQW_EN) | (32'h1 << cpoe_pkg::CTRL_TERM_OE);
	localparam logic [31:0] FLUSH = SQ | (32'h1 << cpoe_pkg::CTRL_FLUSH);
	logic clk_sys_i, rst_i, ce_i, wr_i, rd_i, sample_clk_i, gate_i;
	logic [7:0] addr_i;
	logic [31:0] wdata_i, rdata_o, st;
	logic source_i, tb_20m_i, tb_100k_i, pulse_o, sqw_o, io_term_o, io_term_oe_o;
	int miscompares, n_checks, cyc, lo, hi, c;

	cpoe_top cpoe_top_inst (.clk_sys_i, .rst_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.source_i, .gate_i, .sample_clk_i, .tb_20m_i, .tb_100k_i, .pulse_o, .sqw_o, .io_term_o,
		.io_term_oe_o);
	cpoe_src_model #(.SRC_HALF(SP / 2), .FAST_HALF(P20 / 2), .SLOW_HALF(P100 / 2))
		cpoe_src_model_inst (.clk_sys_i, .rst_i, .source_o(source_i), .tb_fast_o(tb_20m_i),
		.tb_slow_o(tb_100k_i));

	////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		@(posedge clk_sys_i);
		st = rdata_o;
	endtask : rd
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(st, e);
	endtask : rc
	task automatic smp();
		sample_clk_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		sample_clk_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask : smp
	// Skips the pulse in progress or else the next one, then times one whole low and high phase.
	task automatic meas(input bit sq);
		lo = 0;
		hi = 0;
		while ((sq ? sqw_o : pulse_o) !== 1'b1) @(posedge clk_sys_i);
		while ((sq ? sqw_o : pulse_o) !== 1'b0) @(posedge clk_sys_i);
		while ((sq ? sqw_o : pulse_o) === 1'b0) begin
			lo++;
			@(posedge clk_sys_i);
		end
		while ((sq ? sqw_o : pulse_o) === 1'b1) begin
			hi++;
			@(posedge clk_sys_i);
		end
	endtask : meas
	task automatic spec(input int i, input int a);
		meas(1'b0);
		chk(lo, i * SP);
		chk(hi, a * SP);
	endtask : spec
	task automatic sqw_case(input logic [1:0] sel, input logic [4:0] d, input int p);
		int de;
		de = (d == 5'h00) ? 1 : ((d > 5'h10) ? 16 : int'(d));
		wr(cpoe_pkg::OFS_SQW, {25'h0, sel, d});
		meas(1'b1);
		meas(1'b1);
		chk(lo, (de == 1) ? p / 2 : ((de + 1) / 2) * p);
		chk(hi, (de == 1) ? p / 2 : (de / 2) * p);
	endtask : sqw_case
	// The gate rises just after a falling Source edge, mid-way between rising edges, so no count is ambiguous.
	task automatic trig();
		while (source_i !== 1'b1) @(posedge clk_sys_i);
		while (source_i !== 1'b0) @(posedge clk_sys_i);
		gate_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		gate_i <= 1'b0;
	endtask : trig
	task automatic swp_delay(input int d);
		while (pulse_o !== 1'b0) @(posedge clk_sys_i);
		trig();
		c = 2;
		while (pulse_o !== 1'b1) begin
			c++;
			@(posedge clk_sys_i);
		end
		chk((c + SP - 1) / SP, d);
	endtask : swp_delay
	task automatic print_verdict();
		if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : print_verdict

	////////////////////////////////////////
	initial begin
		clk_sys_i = 1'b0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 40000) begin
			miscompares++;
			print_verdict();
		end
	end

	initial begin
		{rst_i, ce_i, wr_i, rd_i, sample_clk_i, gate_i} <= 6'h30;
		addr_i <= 8'h00;
		wdata_i <= 32'h0;
		repeat (16) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		@(posedge clk_sys_i);
		chk(io_term_oe_o, 1'b0);
		rc(R_CTL, {24'h0, cpoe_pkg::CTRL_RESET});
		rc(cpoe_pkg::OFS_DFLT, {cpoe_pkg::TICK_RESET, cpoe_pkg::TICK_RESET});
		rc(R_ST, 32'h0);
		rc(8'h40, 32'h0);
		// With the clock enable low a write must leave no trace.
		ce_i <= 1'b0;
		wr(cpoe_pkg::OFS_COUNT, 32'h7);
		ce_i <= 1'b1;
		rc(cpoe_pkg::OFS_COUNT, 32'h0);
		wr(R_CTL, SQ);
		sqw_case(cpoe_pkg::TB_100K, 5'h05, P100);
		sqw_case(2'h3, 5'h03, P100);
		sqw_case(cpoe_pkg::TB_100K, 5'h00, P100);
		sqw_case(cpoe_pkg::TB_100K, 5'h1F, P100);
		sqw_case(cpoe_pkg::TB_20M, 5'h02, P20);
		sqw_case(cpoe_pkg::TB_10M, 5'h04, 2 * P20);
		chk(io_term_oe_o, 1'b1);
		wr(cpoe_pkg::OFS_DELAY, 32'h3);
		wr(cpoe_pkg::OFS_COUNT, 32'h3);
		wr(R_FIFO, 32'h0003_0003);
		wr(R_FIFO, 32'h0002_0002);
		rc(R_ST, 32'h0000_0200);
		wr(R_CTL, SQ | ARM);
		wr(R_FIFO, 32'h0003_0003);
		spec(2, 2);
		smp();
		spec(3, 3);
		smp();
		spec(2, 2);
		smp();
		spec(3, 3);
		smp();
		spec(3, 3);
		rd(R_ST);
		chk({st[14:8], st[1:0]}, 32'h0);
		wr(R_CTL, FLUSH);
		wr(cpoe_pkg::OFS_COUNT, 32'h1);
		wr(R_FIFO, 32'h0003_0001);
		wr(R_FIFO, 32'h0001_0002);
		wr(R_CTL, SQ | CONT | ARM | ({30'h0, cpoe_pkg::REGEN_NONE} << cpoe_pkg::CTRL_REGEN_LO)
			| (32'h1 << cpoe_pkg::CTRL_SRC_FALL));
		meas(1'b0);
		smp();
		spec(1, 3);
		smp();
		spec(2, 1);
		smp();
		meas(1'b0);
		rd(R_ST);
		chk(st[cpoe_pkg::ST_UNDERFLOW], 1'b1);
		wr(R_ST, 32'h1 << cpoe_pkg::ST_UNDERFLOW);
		rd(R_ST);
		chk(st[cpoe_pkg::ST_UNDERFLOW], 1'b0);
		wr(R_CTL, FLUSH);
		// Two words fit the FIFO, so replay from it is allowed.
		wr(R_FIFO, 32'h0002_0001);
		wr(R_FIFO, 32'h0001_0002);
		wr(R_CTL, SQ | CONT | ARM | ({30'h0, cpoe_pkg::REGEN_FIFO} << cpoe_pkg::CTRL_REGEN_LO));
		wr(R_FIFO, 32'h0004_0004);
		rd(R_ST);
		chk({st[14:8], st[cpoe_pkg::ST_LOADED], st[cpoe_pkg::ST_REFUSED]}, 32'h0B);
		meas(1'b0);
		smp();
		spec(1, 2);
		smp();
		spec(2, 1);
		smp();
		spec(1, 2);
		wr(R_CTL, SQ);
		wr(cpoe_pkg::OFS_SWP, 32'h00FF_0002);
		wr(R_CTL, SQ | ARM | (32'h1 << cpoe_pkg::CTRL_SWP));
		swp_delay(2);
		trig();
		swp_delay(257);
		swp_delay(512);
		print_verdict();
	end
endmodule : tb_top
